//--- verilog/poc_defs.vh
// Constants for the port overall controller
`ifndef POC_DEFS_VH
`define POC_DEFS_VH
`define POC_RT_RETRY 3'h0
`define POC_RT_NODEST 3'h1
`define POC_RT_OPENTO 3'h2
`define POC_RT_PBLK 3'h3
`define POC_RT_OBDEST 3'h4
`define POC_RT_OBOTHER 3'h5
`define POC_RT_COLLIDED 3'h6
`define POC_TS_NO_PHYS 3'h1
`define POC_TS_NEXUS_LOSS 3'h2
`define POC_TS_NO_DEST 3'h3
`define POC_TS_OPEN_TO 3'h4
`define POC_LOSS_OFF 16'h0000
`define POC_LOSS_NEVER 16'hFFFF
`define POC_PBC_MAX 8'hFF
`define POC_AWT_DEFAULT 15'h0000
`define POC_AWT_MAX 15'h7FFF
`define POC_AGE_MAX 8'hFF
`define POC_LOSS_UNIT_NS 1000000
`define POC_CLK_NS 4
`endif

//--- verilog/poc_port_overall_controller.v
// Port overall controller: frame queue, open slots, nexus-loss timers
// What this block does
// - Hard reset confirmed in both states; active state also flushes frames and timers
// - Idle state answers every transmit request with a no-phys status
// - Idle timer expiry removes timer, reports and drops its frames and opens
// - Starts idle; goes active once any assigned phy is enabled
// - Active state queues one entry per request or frame retry; one SMP entry
// - Opens only via enabled, non-busy phy managers; wait for their reply
// - New timer only for SSP, target, mode page present, nonzero loss time
// - A new timer is loaded with its initial value and left stopped
// - Initiator ports may optionally create timers from configured loss time
// - Timer removed once no queued frames remain for its destination
// - Plain retry is retried; running timer stopped and reloaded
// - No-destination or open-timeout without timer: retry or fail, by parameter
// - Pathway-blocked retry without timer is retried
// - Timer with initial FFFFh never turns those outcomes into failures
// - No-dest/timeout with timer: start stopped, keep running, expired fails
// - Pathway-blocked with timer: keep running, expired fails
// - Open slot made when free slot, no open and frame queued for destination
// - A retry that cannot become an open is dropped
// - Opened-by-destination retry takes a new open slot when one is free
// - Dispatch only to enabled idle phys, oldest pending open first
// - Retry-born opens of four kinds load and start an arbitration wait timer
// - Open carries role bit, protocol, rate, tag, addresses, count, wait time
// - Request or plain-kind retry opens carry zero count and default wait
`include "poc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module poc_port_overall_controller #(
   parameter NPHY = 4,
   parameter NFRM = 8,
   parameter NDEST = 4,
   parameter NODEST_AS_FAIL = 0,
   parameter LOSS_TICK_CYC = `POC_LOSS_UNIT_NS / `POC_CLK_NS
) (
   input wire core_clk,
   input wire rstn,
   input wire [NPHY-1:0] phy_enabled,
   input wire [NPHY-1:0] pm_connected,
   input wire [NPHY-1:0] pm_response,
   input wire cfg_target_port,
   input wire cfg_mode_page_present,
   input wire cfg_initiator_timers,
   input wire [15:0] cfg_loss_time,
   input wire hard_reset_ind,
   output reg hard_reset_cnf,
   input wire tx_valid,
   output wire tx_ready,
   input wire tx_smp,
   input wire tx_init_bit,
   input wire [1:0] tx_proto,
   input wire [3:0] tx_rate,
   input wire [15:0] tx_tag,
   input wire [63:0] tx_dest,
   input wire [63:0] tx_src,
   input wire frame_retry_valid,
   input wire [$clog2(NFRM)-1:0] frame_retry_idx,
   input wire frame_sent_valid,
   input wire [$clog2(NFRM)-1:0] frame_sent_idx,
   input wire retry_valid,
   output wire retry_ready,
   input wire [2:0] retry_kind,
   input wire [$clog2(NFRM)-1:0] retry_idx,
   input wire [14:0] retry_awt,
   input wire [7:0] retry_pbc,
   output reg open_valid,
   output reg [((NPHY>1)?$clog2(NPHY):1)-1:0] open_phy,
   output reg [$clog2(NFRM)-1:0] open_idx,
   output reg open_init_bit,
   output reg [1:0] open_proto,
   output reg [3:0] open_rate,
   output reg [15:0] open_tag,
   output reg [63:0] open_dest,
   output reg [63:0] open_src,
   output reg [7:0] open_pbc,
   output reg [14:0] open_awt,
   output reg status_valid,
   output reg [2:0] status_code,
   output reg [15:0] status_tag,
   output reg [63:0] status_dest,
   output reg active
);
   localparam FW = $clog2(NFRM);
   localparam PW = (NPHY > 1) ? $clog2(NPHY) : 1;
   localparam DW = (NDEST > 1) ? $clog2(NDEST) : 1;
   localparam ST_IDLE = 1'b0;
   localparam ST_ACTIVE = 1'b1;

   reg state_reg;
   reg [31:0] tick_reg;
   reg [NPHY-1:0] pm_busy_reg;
   reg [NFRM-1:0] f_v_reg, f_ho_reg, f_smp_reg, f_ib_reg;
   reg [1:0] f_proto_reg [0:NFRM-1];
   reg [3:0] f_rate_reg [0:NFRM-1];
   reg [15:0] f_tag_reg [0:NFRM-1];
   reg [63:0] f_dest_reg [0:NFRM-1];
   reg [63:0] f_src_reg [0:NFRM-1];
   reg [NDEST-1:0] t_v_reg, t_run_reg, t_exp_reg, t_die_reg;
   reg [63:0] t_addr_reg [0:NDEST-1];
   reg [15:0] t_init_reg [0:NDEST-1];
   reg [15:0] t_cnt_reg [0:NDEST-1];
   reg [NPHY-1:0] o_v_reg, o_run_reg;
   reg [FW-1:0] o_frm_reg [0:NPHY-1];
   reg [7:0] o_pbc_reg [0:NPHY-1];
   reg [14:0] o_awt_reg [0:NPHY-1];
   reg [7:0] o_age_reg [0:NPHY-1];

   integer ci, cj, si;
   reg ff_hit, smp_busy, txt_hit, tf_hit, rt_hit, r_dup, dr_hit, df_hit;
   reg oc_hit, os_hit, ds_hit, dp_hit, dup;
   reg [FW-1:0] ff_idx, df_idx, oc_idx;
   reg [DW-1:0] tf_idx, rt_idx, dr_idx;
   reg [PW-1:0] os_idx, ds_idx, dp_idx;
   reg [NDEST-1:0] tref;
   reg r_fail, r_loss, r_stop, r_start, never;
   wire tick = (tick_reg == LOSS_TICK_CYC - 1);
   wire [63:0] r_dest = f_dest_reg[retry_idx];
   wire r_take = retry_valid && retry_ready;
   wire r_conv = !r_fail && !r_loss && os_hit && !r_dup && f_v_reg[retry_idx];
   wire r_wait = (retry_kind == `POC_RT_PBLK) || (retry_kind == `POC_RT_OBDEST) ||
                 (retry_kind == `POC_RT_OBOTHER) || (retry_kind == `POC_RT_COLLIDED);
   wire t_make = !tx_smp && (cfg_loss_time != `POC_LOSS_OFF) &&
                 ((cfg_target_port && cfg_mode_page_present) ||
                  (!cfg_target_port && cfg_initiator_timers));

   // idle accepts unless a retry or dying timer is pending; one SMP entry at a time
   assign tx_ready = !dr_hit && !retry_valid &&
                     ((state_reg == ST_IDLE) || (ff_hit && !(tx_smp && smp_busy)));
   assign retry_ready = !dr_hit;

   always @* begin
      ff_hit = 1'b0; ff_idx = {FW{1'b0}}; smp_busy = 1'b0;
      txt_hit = 1'b0; tf_hit = 1'b0; tf_idx = {DW{1'b0}};
      rt_hit = 1'b0; rt_idx = {DW{1'b0}}; r_dup = 1'b0;
      dr_hit = 1'b0; dr_idx = {DW{1'b0}}; df_hit = 1'b0; df_idx = {FW{1'b0}};
      oc_hit = 1'b0; oc_idx = {FW{1'b0}}; os_hit = 1'b0; os_idx = {PW{1'b0}};
      ds_hit = 1'b0; ds_idx = {PW{1'b0}}; dp_hit = 1'b0; dp_idx = {PW{1'b0}};
      tref = {NDEST{1'b0}}; dup = 1'b0;
      for (ci = NFRM - 1; ci >= 0; ci = ci - 1) begin
         if (!f_v_reg[ci]) begin
            ff_hit = 1'b1;
            ff_idx = ci[FW-1:0];
         end
         if (f_v_reg[ci] && f_smp_reg[ci])
            smp_busy = 1'b1;
      end
      for (ci = NDEST - 1; ci >= 0; ci = ci - 1) begin
         if (!t_v_reg[ci]) begin
            tf_hit = 1'b1;
            tf_idx = ci[DW-1:0];
         end
         if (t_v_reg[ci] && t_addr_reg[ci] == tx_dest)
            txt_hit = 1'b1;
         if (t_v_reg[ci] && t_addr_reg[ci] == r_dest) begin
            rt_hit = 1'b1;
            rt_idx = ci[DW-1:0];
         end
         if (t_v_reg[ci] && t_die_reg[ci]) begin
            dr_hit = 1'b1;
            dr_idx = ci[DW-1:0];
         end
         for (cj = 0; cj < NFRM; cj = cj + 1)
            if (f_v_reg[cj] && f_dest_reg[cj] == t_addr_reg[ci])
               tref[ci] = 1'b1;
      end
      for (ci = NFRM - 1; ci >= 0; ci = ci - 1)
         if (dr_hit && f_v_reg[ci] && f_dest_reg[ci] == t_addr_reg[dr_idx]) begin
            df_hit = 1'b1;
            df_idx = ci[FW-1:0];
         end
      // one pending open per destination, slots bounded by phy count
      for (ci = NFRM - 1; ci >= 0; ci = ci - 1) begin
         dup = 1'b0;
         for (cj = 0; cj < NPHY; cj = cj + 1)
            if (o_v_reg[cj] && f_dest_reg[o_frm_reg[cj]] == f_dest_reg[ci])
               dup = 1'b1;
         if (f_v_reg[ci] && !f_ho_reg[ci] && !dup) begin
            oc_hit = 1'b1;
            oc_idx = ci[FW-1:0];
         end
      end
      for (ci = NPHY - 1; ci >= 0; ci = ci - 1) begin
         if (!o_v_reg[ci]) begin
            os_hit = 1'b1;
            os_idx = ci[PW-1:0];
         end
         if (o_v_reg[ci] && f_dest_reg[o_frm_reg[ci]] == r_dest)
            r_dup = 1'b1;
         // only enabled phys whose manager has answered
         if (phy_enabled[ci] && !pm_busy_reg[ci] && !pm_connected[ci]) begin
            dp_hit = 1'b1;
            dp_idx = ci[PW-1:0];
         end
      end
      for (ci = 0; ci < NPHY; ci = ci + 1)
         if (o_v_reg[ci] && (!ds_hit || o_age_reg[ci] > o_age_reg[ds_idx])) begin
            ds_hit = 1'b1;
            ds_idx = ci[PW-1:0];
         end
   end

   always @* begin
      r_fail = 1'b0; r_loss = 1'b0; r_stop = 1'b0; r_start = 1'b0;
      never = (t_init_reg[rt_idx] == `POC_LOSS_NEVER);
      case (retry_kind)
         // plain retry reloads a running timer
         `POC_RT_RETRY: r_stop = rt_hit && t_run_reg[rt_idx];
         `POC_RT_NODEST, `POC_RT_OPENTO: begin
            // no timer: fixed choice; FFFFh never fails; states
            if (!rt_hit)
               r_fail = (NODEST_AS_FAIL != 0);
            else if (!never) begin
               if (t_exp_reg[rt_idx])
                  r_loss = 1'b1;
               else if (!t_run_reg[rt_idx])
                  r_start = 1'b1;
            end
         end
         // no timer retried; only expiry fails
         `POC_RT_PBLK: r_loss = rt_hit && !never && t_exp_reg[rt_idx];
         default: r_fail = 1'b0;
      endcase
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         active <= 1'b0;
         tick_reg <= 32'h0000_0000;
         pm_busy_reg <= {NPHY{1'b0}};
         f_v_reg <= {NFRM{1'b0}};
         f_ho_reg <= {NFRM{1'b0}};
         t_v_reg <= {NDEST{1'b0}};
         t_die_reg <= {NDEST{1'b0}};
         o_v_reg <= {NPHY{1'b0}};
         hard_reset_cnf <= 1'b0;
         open_valid <= 1'b0;
         status_valid <= 1'b0;
      end else begin
         open_valid <= 1'b0;
         status_valid <= 1'b0;
         hard_reset_cnf <= hard_reset_ind;
         tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
         pm_busy_reg <= pm_busy_reg & ~pm_response;
         active <= (state_reg == ST_ACTIVE);
         // first enabled phy moves to active
         if (state_reg == ST_IDLE && |phy_enabled)
            state_reg <= ST_ACTIVE;
         for (si = 0; si < NDEST; si = si + 1) begin
            if (t_run_reg[si] && tick) begin
               if (t_cnt_reg[si] <= 16'h0001) begin
                  t_run_reg[si] <= 1'b0;
                  t_exp_reg[si] <= 1'b1;
               end else
                  t_cnt_reg[si] <= t_cnt_reg[si] - 16'h0001;
            end
            // expiry in idle flushes that destination
            if (state_reg == ST_IDLE && t_v_reg[si] && t_exp_reg[si])
               t_die_reg[si] <= 1'b1;
            // timer removed with its last frame
            if (t_v_reg[si] && !tref[si]) begin
               t_v_reg[si] <= 1'b0;
               t_die_reg[si] <= 1'b0;
            end
         end
         for (si = 0; si < NPHY; si = si + 1) begin
            if (o_age_reg[si] != `POC_AGE_MAX)
               o_age_reg[si] <= o_age_reg[si] + 8'h01;
            if (o_run_reg[si] && o_awt_reg[si] != `POC_AWT_MAX)
               o_awt_reg[si] <= o_awt_reg[si] + 15'h0001;
         end
         if (ds_hit && dp_hit && state_reg == ST_ACTIVE) begin
            // open fields from the queued request
            open_valid <= 1'b1;
            open_phy <= dp_idx;
            open_idx <= o_frm_reg[ds_idx];
            open_init_bit <= f_ib_reg[o_frm_reg[ds_idx]];
            open_proto <= f_proto_reg[o_frm_reg[ds_idx]];
            open_rate <= f_rate_reg[o_frm_reg[ds_idx]];
            open_tag <= f_tag_reg[o_frm_reg[ds_idx]];
            open_dest <= f_dest_reg[o_frm_reg[ds_idx]];
            open_src <= f_src_reg[o_frm_reg[ds_idx]];
            open_pbc <= o_pbc_reg[ds_idx];
            open_awt <= o_awt_reg[ds_idx];
            o_v_reg[ds_idx] <= 1'b0;
            pm_busy_reg[dp_idx] <= 1'b1;
         end
         if (tx_valid && tx_ready) begin
            if (state_reg == ST_IDLE) begin
               status_valid <= 1'b1;
               status_code <= `POC_TS_NO_PHYS;
               status_tag <= tx_tag;
               status_dest <= tx_dest;
            end else begin
               f_v_reg[ff_idx] <= 1'b1;
               f_ho_reg[ff_idx] <= 1'b0;
               f_smp_reg[ff_idx] <= tx_smp;
               f_ib_reg[ff_idx] <= tx_init_bit;
               f_proto_reg[ff_idx] <= tx_proto;
               f_rate_reg[ff_idx] <= tx_rate;
               f_tag_reg[ff_idx] <= tx_tag;
               f_dest_reg[ff_idx] <= tx_dest;
               f_src_reg[ff_idx] <= tx_src;
               if (!txt_hit && tf_hit && t_make) begin
                  t_v_reg[tf_idx] <= 1'b1;
                  t_die_reg[tf_idx] <= 1'b0;
                  t_run_reg[tf_idx] <= 1'b0;
                  t_exp_reg[tf_idx] <= 1'b0;
                  t_addr_reg[tf_idx] <= tx_dest;
                  t_init_reg[tf_idx] <= cfg_loss_time;
                  t_cnt_reg[tf_idx] <= cfg_loss_time;
               end
            end
         end
         if (state_reg == ST_ACTIVE && oc_hit && os_hit && !retry_valid && !dr_hit) begin
            o_v_reg[os_idx] <= 1'b1;
            o_run_reg[os_idx] <= 1'b0;
            o_frm_reg[os_idx] <= oc_idx;
            o_pbc_reg[os_idx] <= 8'h00;
            o_awt_reg[os_idx] <= `POC_AWT_DEFAULT;
            o_age_reg[os_idx] <= 8'h00;
            f_ho_reg[oc_idx] <= 1'b1;
         end
         // a frame retry is queued again
         if (frame_retry_valid)
            f_ho_reg[frame_retry_idx] <= 1'b0;
         if (frame_sent_valid)
            f_v_reg[frame_sent_idx] <= 1'b0;
         if (r_take) begin
            // unconverted retry dropped, frame may reopen later
            f_ho_reg[retry_idx] <= r_conv;
            if (r_stop) begin
               t_run_reg[rt_idx] <= 1'b0;
               t_cnt_reg[rt_idx] <= t_init_reg[rt_idx];
            end
            if (r_start)
               t_run_reg[rt_idx] <= 1'b1;
            if (r_loss)
               t_die_reg[rt_idx] <= 1'b1;
            if (r_fail) begin
               status_valid <= 1'b1;
               status_code <= (retry_kind == `POC_RT_NODEST) ? `POC_TS_NO_DEST :
                              `POC_TS_OPEN_TO;
               status_tag <= f_tag_reg[retry_idx];
               status_dest <= r_dest;
               f_v_reg[retry_idx] <= 1'b0;
            end
            if (r_conv) begin
               o_v_reg[os_idx] <= 1'b1;
               o_frm_reg[os_idx] <= retry_idx;
               o_age_reg[os_idx] <= 8'h00;
               o_run_reg[os_idx] <= r_wait;
               o_awt_reg[os_idx] <= r_wait ? retry_awt : `POC_AWT_DEFAULT;
               if (retry_kind == `POC_RT_PBLK)
                  o_pbc_reg[os_idx] <= (retry_pbc == `POC_PBC_MAX) ? retry_pbc :
                                       retry_pbc + 8'h01;
               else
                  o_pbc_reg[os_idx] <= r_wait ? retry_pbc : 8'h00;
            end
         end
         // report and drop each frame of a dying destination
         if (df_hit) begin
            status_valid <= 1'b1;
            status_code <= `POC_TS_NEXUS_LOSS;
            status_tag <= f_tag_reg[df_idx];
            status_dest <= f_dest_reg[df_idx];
            f_v_reg[df_idx] <= 1'b0;
            for (si = 0; si < NPHY; si = si + 1)
               if (o_frm_reg[si] == df_idx)
                  o_v_reg[si] <= 1'b0;
         end
         if (hard_reset_ind && state_reg == ST_ACTIVE) begin
            f_v_reg <= {NFRM{1'b0}};
            t_v_reg <= {NDEST{1'b0}};
            t_die_reg <= {NDEST{1'b0}};
            o_v_reg <= {NPHY{1'b0}};
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/poc_pm_model.sv
// Phy manager model: answers each open after a short or long delay
`timescale 1ns/1ps
`default_nettype none
module poc_pm_model #(
   parameter NPHY = 4
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic open_valid,
   input wire logic [((NPHY>1)?$clog2(NPHY):1)-1:0] open_phy,
   input wire logic slow,
   input wire logic [NPHY-1:0] link_held,
   output logic [NPHY-1:0] pm_response = '0,
   output logic [NPHY-1:0] pm_connected = '0
);
   int wait_cnt [NPHY];
   always @(posedge core_clk) begin
      pm_response <= '0;
      pm_connected <= link_held;
      for (int i = 0; i < NPHY; i++) begin
         if (!rstn)
            wait_cnt[i] <= 0;
         else if (open_valid && open_phy == i)
            wait_cnt[i] <= slow ? 12 : 2;
         else if (wait_cnt[i] == 1) begin
            pm_response[i] <= 1'b1;
            wait_cnt[i] <= 0;
         end else if (wait_cnt[i] > 1)
            wait_cnt[i] <= wait_cnt[i] - 1;
      end
   end
endmodule
`default_nettype wire

//--- tb/poc_ctl_sva.sv
// Assertion checker for the port overall controller
`include "poc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module poc_ctl_sva #(
   parameter NPHY = 4
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [NPHY-1:0] phy_enabled,
   input wire logic [NPHY-1:0] pm_connected,
   input wire logic [NPHY-1:0] pm_response,
   input wire logic hard_reset_ind,
   input wire logic hard_reset_cnf,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [15:0] tx_tag,
   input wire logic retry_valid,
   input wire logic open_valid,
   input wire logic [((NPHY>1)?$clog2(NPHY):1)-1:0] open_phy,
   input wire logic status_valid,
   input wire logic [2:0] status_code,
   input wire logic [15:0] status_tag,
   input wire logic active
);
   logic [NPHY-1:0] busy_reg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Managers sent an open and not yet answered
   always @(posedge core_clk) begin
      if (!rstn)
         busy_reg <= '0;
      else
         busy_reg <= (busy_reg & ~pm_response) | ({NPHY{open_valid}} & (NPHY'(1) << open_phy));
   end
   a_hr_confirm: assert property (hard_reset_ind |=> hard_reset_cnf)
      else $error("hard reset not confirmed");
   a_hr_cause: assert property (hard_reset_cnf |-> $past(hard_reset_ind))
      else $error("confirmation without hard reset");
   a_idle_nophys: assert property (
      tx_valid && tx_ready && !active && phy_enabled == '0 && $past(phy_enabled) == '0
      |=> status_valid && status_code == `POC_TS_NO_PHYS && status_tag == $past(tx_tag))
      else $error("idle request not answered with no phys");
   a_reset_idle: assert property ($rose(rstn) |-> !active && !open_valid && !status_valid)
      else $error("not idle after reset");
   a_go_active: assert property (phy_enabled != '0 && !active |-> ##[1:3] active)
      else $error("enabled phy did not activate");
   a_active_cause: assert property (
      $rose(active) |-> $past(phy_enabled) != '0 || $past(phy_enabled, 2) != '0)
      else $error("active without enabled phy");
   a_open_enabled: assert property (
      open_valid |-> phy_enabled[open_phy] && !pm_connected[open_phy])
      else $error("open sent to unusable phy");
   a_phy_wait: assert property (open_valid |-> !busy_reg[open_phy])
      else $error("second open before manager answered");
   a_idle_no_open: assert property (!active |-> !open_valid)
      else $error("open sent while idle");
   a_retry_excl: assert property (retry_valid |-> !tx_ready)
      else $error("request taken beside a retry");
   c_open: cover property (open_valid && active);
   c_loss: cover property (status_valid && status_code == `POC_TS_NEXUS_LOSS);
   c_hr_active: cover property (hard_reset_cnf && active);
endmodule
bind poc_port_overall_controller poc_ctl_sva #(.NPHY(NPHY)) u_poc_ctl_sva (.core_clk, .rstn,
   .phy_enabled, .pm_connected, .pm_response, .hard_reset_ind, .hard_reset_cnf, .tx_valid,
   .tx_ready, .tx_tag, .retry_valid, .open_valid, .open_phy, .status_valid, .status_code,
   .status_tag, .active);
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the port overall controller
`include "poc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam NPHY = 4;
   localparam [63:0] DEST_A = 64'h5000_0000_0000_00a1;
   localparam [63:0] DEST_B = 64'h5000_0000_0000_00b2;
   localparam [63:0] DEST_C = 64'h5000_0000_0000_00c3;
   logic core_clk = 1'b0, rstn = 1'b0, slow = 1'b0, hard_reset_ind = 1'b0;
   logic cfg_target_port = 1'b0, cfg_mode_page_present = 1'b1, cfg_initiator_timers = 1'b0;
   logic [NPHY-1:0] phy_enabled = '0, link_held = 4'h1, pm_connected, pm_response;
   logic [15:0] cfg_loss_time = 16'h0000, tx_tag = 16'h0000, status_tag, open_tag;
   logic tx_valid = 1'b0, tx_smp = 1'b0, tx_init_bit = 1'b0, tx_ready, retry_ready;
   logic [1:0] tx_proto = 2'h0, open_proto, open_phy;
   logic [3:0] tx_rate = 4'h0, open_rate;
   logic [63:0] tx_dest = '0, tx_src = '0, open_dest, open_src, status_dest;
   logic frame_retry_valid = 1'b0, frame_sent_valid = 1'b0, retry_valid = 1'b0;
   logic [2:0] frame_retry_idx = '0, frame_sent_idx = '0, retry_idx = '0, retry_kind = '0;
   logic [2:0] open_idx, status_code, idx_r;
   logic [14:0] retry_awt = '0, open_awt;
   logic [7:0] retry_pbc = '0, open_pbc;
   logic open_valid, open_init_bit, status_valid, active, hard_reset_cnf;
   int n_fail = 0, checked = 0, cycles = 0;

   poc_port_overall_controller #(.NPHY(NPHY), .LOSS_TICK_CYC(10)) u_poc_port_overall_controller (
      .core_clk, .rstn, .phy_enabled, .pm_connected, .pm_response, .cfg_target_port,
      .cfg_mode_page_present, .cfg_initiator_timers, .cfg_loss_time, .hard_reset_ind,
      .hard_reset_cnf, .tx_valid, .tx_ready, .tx_smp, .tx_init_bit, .tx_proto, .tx_rate,
      .tx_tag, .tx_dest, .tx_src, .frame_retry_valid, .frame_retry_idx, .frame_sent_valid,
      .frame_sent_idx, .retry_valid, .retry_ready, .retry_kind, .retry_idx, .retry_awt,
      .retry_pbc, .open_valid, .open_phy, .open_idx, .open_init_bit, .open_proto, .open_rate,
      .open_tag, .open_dest, .open_src, .open_pbc, .open_awt, .status_valid, .status_code,
      .status_tag, .status_dest, .active);
   poc_pm_model #(.NPHY(NPHY)) u_poc_pm_model (.core_clk, .rstn, .open_valid, .open_phy,
      .slow, .link_held, .pm_response, .pm_connected);

   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t: got %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic send_tx(input logic smp, input logic [15:0] tag, input logic [63:0] dest);
      @(posedge core_clk);
      tx_valid <= 1'b1;
      tx_smp <= smp;
      tx_tag <= tag;
      tx_dest <= dest;
      tx_src <= ~dest;
      tx_init_bit <= tag[0];
      tx_proto <= tag[2:1];
      tx_rate <= tag[7:4];
      @(posedge core_clk);
      for (int n = 0; n < 100 && tx_ready !== 1'b1; n++)
         @(posedge core_clk);
      chk(tx_ready, 1'b1);
      tx_valid <= 1'b0;
   endtask
   task automatic send_retry(input logic [2:0] kind, input logic [2:0] idx,
      input logic [14:0] awt, input logic [7:0] pbc);
      @(posedge core_clk);
      retry_valid <= 1'b1;
      retry_kind <= kind;
      retry_idx <= idx;
      retry_awt <= awt;
      retry_pbc <= pbc;
      @(posedge core_clk);
      for (int n = 0; n < 100 && retry_ready !== 1'b1; n++)
         @(posedge core_clk);
      chk(retry_ready, 1'b1);
      retry_valid <= 1'b0;
   endtask
   task automatic pulse_frame(input logic sent, input logic [2:0] idx);
      @(posedge core_clk);
      frame_sent_valid <= sent;
      frame_retry_valid <= !sent;
      frame_sent_idx <= idx;
      frame_retry_idx <= idx;
      @(posedge core_clk);
      frame_sent_valid <= 1'b0;
      frame_retry_valid <= 1'b0;
   endtask
   task automatic pulse_hr();
      @(posedge core_clk);
      hard_reset_ind <= 1'b1;
      @(posedge core_clk);
      hard_reset_ind <= 1'b0;
      #1;
      chk(hard_reset_cnf, 1'b1);
   endtask
   task automatic wait_open();
      for (int n = 0; n < 200 && open_valid !== 1'b1; n++)
         tick();
      chk(open_valid, 1'b1);
   endtask
   task automatic wait_status();
      // Let the launching edge settle so a pulse from it is not missed
      #1;
      for (int n = 0; n < 50 && status_valid !== 1'b1; n++)
         tick();
      chk(status_valid, 1'b1);
   endtask

   task automatic t_idle();
      send_tx(1'b0, 16'h00a5, DEST_A);
      wait_status();
      chk(status_code, `POC_TS_NO_PHYS);
      chk(status_tag, 16'h00a5);
      chk(status_dest, DEST_A);
      pulse_hr();
      chk(active, 1'b0);
      @(posedge core_clk);
      phy_enabled <= 4'h3;
      for (int n = 0; n < 10 && active !== 1'b1; n++)
         tick();
      chk(active, 1'b1);
   endtask
   task automatic t_open();
      send_tx(1'b0, 16'h1235, DEST_B);
      wait_open();
      chk(open_phy, 2'h1);
      chk(open_tag, 16'h1235);
      chk(open_dest, DEST_B);
      chk(open_src, ~DEST_B);
      chk({open_init_bit, open_proto, open_rate}, 7'h63);
      chk({open_pbc, open_awt}, 23'h0);
      idx_r = open_idx;
   endtask
   // Every retry kind, then a saturated blocked count, with a slow manager
   task automatic t_retry();
      slow <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         send_retry(k == 7 ? 3'h3 : 3'(k), idx_r, 15'h0040, k == 7 ? 8'hff : 8'h05);
         wait_open();
         chk(open_idx, idx_r);
         chk(open_pbc, k < 3 ? 8'h00 : k == 3 ? 8'h06 : k == 7 ? 8'hff : 8'h05);
         chk(k < 3 ? open_awt == 15'h0 : open_awt >= 15'h0040, 1'b1);
      end
      pulse_frame(1'b0, idx_r);
      wait_open();
      chk(open_idx, idx_r);
      slow <= 1'b0;
      pulse_frame(1'b1, idx_r);
   endtask
   // Timer made stopped, started by a failed open, then expires; target or initiator port
   task automatic t_nexus(input logic tgt);
      @(posedge core_clk);
      cfg_target_port <= tgt;
      cfg_initiator_timers <= !tgt;
      cfg_loss_time <= 16'h0002;
      send_tx(1'b0, 16'h2001, DEST_C);
      wait_open();
      idx_r = open_idx;
      repeat (40) tick();
      send_retry(`POC_RT_NODEST, idx_r, 15'h0, 8'h0);
      wait_open();
      chk(open_idx, idx_r);
      repeat (40) tick();
      send_retry(`POC_RT_OPENTO, idx_r, 15'h0, 8'h0);
      wait_status();
      chk(status_code, `POC_TS_NEXUS_LOSS);
      chk(status_tag, 16'h2001);
      chk(status_dest, DEST_C);
   endtask
   task automatic t_smp();
      send_tx(1'b1, 16'h3005, DEST_A);
      @(posedge core_clk);
      tx_valid <= 1'b1;
      tick();
      chk(tx_ready, 1'b0);
      @(posedge core_clk);
      tx_valid <= 1'b0;
      send_tx(1'b0, 16'h3007, DEST_A);
      repeat (30) tick();
      pulse_hr();
      send_tx(1'b1, 16'h3009, DEST_A);
   endtask

   initial begin
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      t_idle();
      t_open();
      t_retry();
      t_nexus(1'b1);
      t_nexus(1'b0);
      t_smp();
      complete_run();
   end
endmodule
`default_nettype wire
